/* File: tsme_cfg.svh */
`ifndef TSME_CFG_SVH
`define TSME_CFG_SVH

// Register numbers of the alternate bank
`define TSME_REG_MODE_CTRL 4'hb
`define TSME_REG_MATCH_CHAR 4'hc
`define TSME_REG_IDLE_CHAR 4'hd

// Field positions in transparent_mode_control
`define TSME_BIT_TEST 7
`define TSME_BIT_RAW 6
`define TSME_BIT_MATCH 5
`define TSME_BIT_HUNT 4
`define TSME_BIT_FOUND 4

// Reset values
`define TSME_RST_MODE_CTRL 8'h00
`define TSME_RST_MATCH_CHAR 8'h00
`define TSME_RST_IDLE_CHAR 8'hff

// Fixed characters and codes
`define TSME_ONES_CHAR 8'hff
`define TSME_FLAG_CHAR 8'h7e
`define TSME_FILL_STATUS 8'h90
`define TSME_OFFSET_NONE 3'h0

// Interframe fill limits, in bits
`define TSME_FILL_SHORT_MAX 3'h5
`define TSME_FILL_SAT 3'h6

`endif

/* File: tsme_pkg.sv */
`default_nettype none

package tsme_pkg;

    // Receiver hunt / load states
    typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_LOAD} tsme_rx_state_type;

    // Transmitter states
    typedef enum logic [0:0] {TX_OFF, TX_RUN} tsme_tx_state_type;

    // One event passed from the receive clock to the host clock
    typedef struct packed {
        logic writeByte;
        logic [7:0] data;
        logic frameEnd;
        logic matchHit;
        logic [2:0] offset;
    } tsme_rx_event_type;

    // Quasi-static settings seen by the receive clock
    typedef struct packed {
        logic enable;
        logic raw;
        logic matchEn;
        logic hunt;
        logic tdm;
        logic msbFirst;
        logic inSel;
        logic [7:0] matchChar;
    } tsme_rx_cfg_type;

    // Quasi-static settings seen by the transmit clock
    typedef struct packed {
        logic enable;
        logic tdm;
        logic msbFirst;
        logic matchEn;
        logic outA;
        logic outB;
        logic [7:0] idleChar;
    } tsme_tx_cfg_type;

endpackage : tsme_pkg

`default_nettype wire

/* File: tsme_engine.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tsme_cfg.svh"

module tsme_engine (
    // Host clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register access
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic regHit,
    output logic [7:0] regRdData,
    // Controls held in other chip registers
    input wire logic bankSelectBit,
    input wire logic txEnableBit,
    input wire logic rxEnableBit,
    input wire logic txResetBit,
    input wire logic rxResetBit,
    input wire logic tdmHighwayEnable,
    input wire logic txOutAEnableBit,
    input wire logic txOutBEnableBit,
    input wire logic rxInputSelect,
    input wire logic txBitOrder,
    input wire logic rxBitOrder,
    // Transmit FIFO side
    input wire logic [7:0] txFifoData,
    input wire logic txFifoValid,
    output logic txFifoPop,
    // Receive FIFO side
    output logic [7:0] rxFifoWrData,
    output logic rxFifoWr,
    // Events
    output logic txFinishedEvent,
    output logic txEmptyEvent,
    output logic underrunAbortEvent,
    output logic rxFrameEndEvent,
    output logic rxIdleEvent,
    // Transmit link
    input wire logic txBitClock,
    input wire logic txSlotActive,
    output logic txOutA,
    output logic txOutAOe,
    output logic txOutB,
    output logic txOutBOe,
    // Receive link
    input wire logic rxBitClock,
    input wire logic rxSlotActive,
    input wire logic rxInA,
    input wire logic rxInB
);

    // ---------------- Host clock domain ----------------
    logic [7:0] modeCtrl_reg;
    logic [7:0] matchChar_reg;
    logic [7:0] idleChar_reg;
    logic patternFound_reg;
    logic [2:0] foundOffset_reg;
    logic rawMode;
    logic matchEn;

    assign rawMode = modeCtrl_reg[`TSME_BIT_RAW];
    assign matchEn = modeCtrl_reg[`TSME_BIT_MATCH];

    // Alternate bank decode
    function automatic logic bankHit(input logic [3:0] a, input logic sel);
        bankHit = sel && (a == `TSME_REG_MODE_CTRL || a == `TSME_REG_MATCH_CHAR || a == `TSME_REG_IDLE_CHAR);
    endfunction : bankHit

    assign regHit = bankHit(regAddr, bankSelectBit);

    // Writable settings; found flag and offset are read-only
    always_ff @(posedge clk) begin
        if (srst) begin
            modeCtrl_reg <= `TSME_RST_MODE_CTRL;
            matchChar_reg <= `TSME_RST_MATCH_CHAR;
            idleChar_reg <= `TSME_RST_IDLE_CHAR;
        end else if (regWr && regHit) begin
            if (regAddr == `TSME_REG_MODE_CTRL) begin
                modeCtrl_reg <= {regWrData[7:4], 4'h0};
            end
            if (regAddr == `TSME_REG_MATCH_CHAR) begin
                matchChar_reg <= regWrData;
            end
            if (regAddr == `TSME_REG_IDLE_CHAR) begin
                idleChar_reg <= regWrData;
            end
        end
    end

    // Registered read data, bit 4 reads back the found flag
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else if (regRd && regHit) begin
            case (regAddr)
                `TSME_REG_MODE_CTRL: regRdData <= {modeCtrl_reg[7:5], patternFound_reg, 1'b0, foundOffset_reg};
                `TSME_REG_MATCH_CHAR: regRdData <= matchChar_reg;
                default: regRdData <= idleChar_reg;
            endcase
        end
    end

    // Reset requests cross as toggles
    logic txRstTgl_reg;
    logic rxRstTgl_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            txRstTgl_reg <= 1'b0;
            rxRstTgl_reg <= 1'b0;
        end else begin
            txRstTgl_reg <= txRstTgl_reg ^ txResetBit;
            rxRstTgl_reg <= rxRstTgl_reg ^ rxResetBit;
        end
    end

    // Transmit holding byte, handed over by toggle and acknowledged back
    logic [7:0] txHold_reg;
    logic txHoldTgl_reg;
    logic txAckTgl_reg;
    logic [1:0] txAckSync_reg;
    logic holdFull;
    assign holdFull = txHoldTgl_reg != txAckSync_reg[1];
    // Prefetch only in raw mode with the transmitter enabled
    assign txFifoPop = !holdFull && txFifoValid && txEnableBit && rawMode;

    always_ff @(posedge clk) begin
        if (srst) begin
            txAckSync_reg <= 2'b00;
            txHoldTgl_reg <= 1'b0;
            txHold_reg <= `TSME_ONES_CHAR;
        end else begin
            txAckSync_reg <= {txAckSync_reg[0], txAckTgl_reg};
            if (txFifoPop) begin
                txHold_reg <= txFifoData;
                txHoldTgl_reg <= !txHoldTgl_reg;
            end
        end
    end

    // Transmit events
    logic txFifoValidPrev_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            txFifoValidPrev_reg <= 1'b0;
            txFinishedEvent <= 1'b0;
            txEmptyEvent <= 1'b0;
        end else begin
            txFifoValidPrev_reg <= txFifoValid;
            txFinishedEvent <= (rawMode && txEnableBit && txFifoValidPrev_reg && !txFifoValid) || txResetBit;
            txEmptyEvent <= txResetBit;
        end
    end
    // Underrun cannot happen: idle fills every gap
    assign underrunAbortEvent = 1'b0;
    // no idle event in raw mode; framing idle lives elsewhere
    assign rxIdleEvent = 1'b0;

    // Receive events arrive by toggle; payload is stable for several bit times
    tsme_pkg::tsme_rx_event_type rxEvt_reg;
    logic rxEvtTgl_reg;
    logic [2:0] rxEvtSync_reg;
    logic rxEvtNew;
    assign rxEvtNew = rxEvtSync_reg[2] != rxEvtSync_reg[1];

    always_ff @(posedge clk) begin
        if (srst) begin
            rxEvtSync_reg <= 3'b000;
            rxFifoWr <= 1'b0;
            rxFifoWrData <= 8'h00;
            rxFrameEndEvent <= 1'b0;
        end else begin
            rxEvtSync_reg <= {rxEvtSync_reg[1:0], rxEvtTgl_reg};
            // match byte is the first write
            rxFifoWr <= rxEvtNew && rxEvt_reg.writeByte;
            if (rxEvtNew && rxEvt_reg.writeByte) begin
                rxFifoWrData <= rxEvt_reg.data;
            end
            // frame end event for short fill
            rxFrameEndEvent <= rxEvtNew && rxEvt_reg.frameEnd;
        end
    end

    // Found flag: set wins over a receiver reset in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            patternFound_reg <= 1'b0;
            foundOffset_reg <= `TSME_OFFSET_NONE;
        end else if (rxEvtNew && rxEvt_reg.matchHit) begin
            patternFound_reg <= 1'b1;
            foundOffset_reg <= rxEvt_reg.offset;
        end else if (rxResetBit) begin
            patternFound_reg <= 1'b0;
            foundOffset_reg <= `TSME_OFFSET_NONE;
        end
    end

    // ---------------- Transmit bit clock domain ----------------
    tsme_pkg::tsme_tx_cfg_type txCfgIn;
    tsme_pkg::tsme_tx_cfg_type txCfgMeta_reg;
    tsme_pkg::tsme_tx_cfg_type txCfg_reg;
    assign txCfgIn = '{enable: txEnableBit && rawMode, tdm: tdmHighwayEnable, msbFirst: txBitOrder,
                       matchEn: matchEn, outA: txOutAEnableBit, outB: txOutBEnableBit, idleChar: idleChar_reg};

    logic [1:0] txSrst_reg;
    logic [2:0] txRstSync_reg;
    logic [1:0] txHoldSync_reg;
    always_ff @(posedge txBitClock) begin
        txCfgMeta_reg <= txCfgIn;
        txCfg_reg <= txCfgMeta_reg;
        txSrst_reg <= {txSrst_reg[0], srst};
        txRstSync_reg <= {txRstSync_reg[1:0], txRstTgl_reg};
        txHoldSync_reg <= {txHoldSync_reg[0], txHoldTgl_reg};
    end

    tsme_pkg::tsme_tx_state_type txState_reg;
    logic [7:0] txShift_reg;
    logic [2:0] txBitCnt_reg;
    logic txSlotPrev_reg;
    logic txStep;
    logic txSlotStart;
    logic txMsb;
    logic [7:0] txIdle;
    logic txRestart;
    assign txMsb = txCfg_reg.tdm && txCfg_reg.msbFirst;
    assign txStep = !txCfg_reg.tdm || txSlotActive;
    assign txSlotStart = txCfg_reg.tdm && txSlotActive && !txSlotPrev_reg;
    assign txIdle = txCfg_reg.matchEn ? txCfg_reg.idleChar : `TSME_ONES_CHAR;
    assign txRestart = txSrst_reg[1] || (txRstSync_reg[2] != txRstSync_reg[1]) || !txCfg_reg.enable;

    // Serialiser
    always_ff @(posedge txBitClock) begin
        if (txRestart) begin
            txState_reg <= tsme_pkg::TX_OFF;
            txShift_reg <= `TSME_ONES_CHAR;
            txBitCnt_reg <= 3'h0;
            txAckTgl_reg <= txHoldSync_reg[1];
            txSlotPrev_reg <= 1'b0;
            txOutA <= 1'b1;
            txOutB <= 1'b1;
        end else begin
            txSlotPrev_reg <= txSlotActive;
            case (txState_reg)
                tsme_pkg::TX_OFF: begin
                    // align to first clock after enable
                    txState_reg <= tsme_pkg::TX_RUN;
                    txShift_reg <= txCfg_reg.tdm ? `TSME_ONES_CHAR : txIdle;
                    txBitCnt_reg <= 3'h0;
                end
                tsme_pkg::TX_RUN: begin
                    if (txStep) begin
                        txOutA <= txMsb ? txShift_reg[7] : txShift_reg[0];
                        txOutB <= txMsb ? txShift_reg[7] : txShift_reg[0];
                        txBitCnt_reg <= txSlotStart ? 3'h1 : 3'(txBitCnt_reg + 3'h1);
                        if (txBitCnt_reg == 3'h7 && !txSlotStart) begin
                            if (txHoldSync_reg[1] != txAckTgl_reg) begin
                                txShift_reg <= txHold_reg;
                                txAckTgl_reg <= txHoldSync_reg[1];
                            end else begin
                                txShift_reg <= txIdle;
                            end
                        end else begin
                            txShift_reg <= txMsb ? {txShift_reg[6:0], 1'b1} : {1'b1, txShift_reg[7:1]};
                        end
                    end
                end
                default: txState_reg <= tsme_pkg::TX_OFF;
            endcase
        end
    end

    // Output enables follow the select bits while running, in TDM only while the slot is active
    always_ff @(posedge txBitClock) begin
        if (txRestart) begin
            txOutAOe <= 1'b0;
            txOutBOe <= 1'b0;
        end else begin
            txOutAOe <= txCfg_reg.outA && txStep;
            txOutBOe <= txCfg_reg.outB && txStep;
        end
    end

    // ---------------- Receive bit clock domain ----------------
    tsme_pkg::tsme_rx_cfg_type rxCfgIn;
    tsme_pkg::tsme_rx_cfg_type rxCfgMeta_reg;
    tsme_pkg::tsme_rx_cfg_type rxCfg_reg;
    assign rxCfgIn = '{enable: rxEnableBit, raw: rawMode, matchEn: matchEn, hunt: modeCtrl_reg[`TSME_BIT_HUNT],
                       tdm: tdmHighwayEnable, msbFirst: rxBitOrder, inSel: rxInputSelect, matchChar: matchChar_reg};

    logic [1:0] rxSrst_reg;
    logic [2:0] rxRstSync_reg;
    always_ff @(posedge rxBitClock) begin
        rxCfgMeta_reg <= rxCfgIn;
        rxCfg_reg <= rxCfgMeta_reg;
        rxSrst_reg <= {rxSrst_reg[0], srst};
        rxRstSync_reg <= {rxRstSync_reg[1:0], rxRstTgl_reg};
    end

    tsme_pkg::tsme_rx_state_type rxState_reg;
    logic [7:0] rxShift_reg;
    logic [2:0] rxBitCnt_reg;
    logic rxSlotPrev_reg;
    logic rxBit;
    logic rxStep;
    logic rxMsb;
    logic rxRestart;
    logic [7:0] rxWindow;
    logic [2:0] rxPos;
    assign rxBit = rxCfg_reg.inSel ? rxInB : rxInA;
    assign rxMsb = rxCfg_reg.tdm && rxCfg_reg.msbFirst;
    assign rxStep = !rxCfg_reg.tdm || rxSlotActive;
    assign rxWindow = rxMsb ? {rxShift_reg[6:0], rxBit} : {rxBit, rxShift_reg[7:1]};
    // Slot start realigns the octet count in TDM
    assign rxPos = (rxCfg_reg.tdm && !rxSlotPrev_reg) ? 3'h0 : rxBitCnt_reg;
    assign rxRestart = rxSrst_reg[1] || (rxRstSync_reg[2] != rxRstSync_reg[1]) || !rxCfg_reg.enable;

    // Event hand-off: one event at a time, spaced by at least a bit time
    function automatic tsme_pkg::tsme_rx_event_type rxMkEvt(input logic wr, input logic [7:0] d,
                                                             input logic fe, input logic hit, input logic [2:0] off);
        rxMkEvt = '{writeByte: wr, data: d, frameEnd: fe, matchHit: hit, offset: off};
    endfunction : rxMkEvt

    // Framing-mode fill watcher state
    logic [7:0] fillHist_reg;
    logic [2:0] fillRun_reg;
    logic [2:0] fillPend_reg;
    logic fillOnly_reg;
    logic fillPendOk_reg;
    logic fillFlag;
    assign fillFlag = {fillHist_reg[6:0], rxBit} == `TSME_FLAG_CHAR;

    // Receive deserialiser, match hunt and fill watcher
    always_ff @(posedge rxBitClock) begin
        if (rxRestart) begin
            rxState_reg <= tsme_pkg::RX_OFF;
            rxShift_reg <= 8'h00;
            rxBitCnt_reg <= 3'h0;
            rxSlotPrev_reg <= 1'b0;
            rxEvtTgl_reg <= 1'b0;
            rxEvt_reg <= rxMkEvt(1'b0, 8'h00, 1'b0, 1'b0, `TSME_OFFSET_NONE);
            fillHist_reg <= 8'h00;
            fillRun_reg <= 3'h0;
            fillPend_reg <= 3'h0;
            fillOnly_reg <= 1'b0;
            fillPendOk_reg <= 1'b0;
        end else if (!rxCfg_reg.raw) begin
            // frame end only in framing mode
            rxState_reg <= tsme_pkg::RX_OFF;
            fillHist_reg <= {fillHist_reg[6:0], rxBit};
            if (fillFlag) begin
                // one bit: frame end, no byte
                // two to five bits: status byte
                if (fillPendOk_reg && fillPend_reg != 3'h0 && fillPend_reg <= `TSME_FILL_SHORT_MAX) begin
                    rxEvt_reg <= rxMkEvt(fillPend_reg != 3'h1, `TSME_FILL_STATUS, 1'b1, 1'b0, `TSME_OFFSET_NONE);
                    rxEvtTgl_reg <= !rxEvtTgl_reg;
                end
                fillOnly_reg <= 1'b1;
                fillRun_reg <= 3'h0;
                fillPendOk_reg <= 1'b0;
            end else if (rxBit) begin
                if (fillRun_reg != `TSME_FILL_SAT) begin
                    fillRun_reg <= 3'(fillRun_reg + 3'h1);
                end
            end else begin
                // A zero ends the run; only a following flag proves it was fill
                fillPend_reg <= fillRun_reg;
                fillPendOk_reg <= fillOnly_reg;
                fillOnly_reg <= 1'b0;
            end
        end else if (rxStep) begin
            rxSlotPrev_reg <= rxSlotActive;
            rxShift_reg <= rxWindow;
            rxBitCnt_reg <= 3'(rxPos + 3'h1);
            case (rxState_reg)
                tsme_pkg::RX_OFF: begin
                    // start at first clock or slot
                    if (rxCfg_reg.matchEn) begin
                        rxState_reg <= tsme_pkg::RX_HUNT;
                    end else begin
                        rxState_reg <= tsme_pkg::RX_LOAD;
                        rxEvt_reg <= rxMkEvt(1'b0, 8'h00, 1'b0, 1'b1, `TSME_OFFSET_NONE);
                        rxEvtTgl_reg <= !rxEvtTgl_reg;
                    end
                    rxBitCnt_reg <= 3'h1;
                end
                tsme_pkg::RX_HUNT: begin
                    if (rxWindow == rxCfg_reg.matchChar && (!rxCfg_reg.hunt || rxPos == 3'h7)) begin
                        rxState_reg <= tsme_pkg::RX_LOAD;
                        rxBitCnt_reg <= 3'h0;
                        rxEvt_reg <= rxMkEvt(1'b1, rxWindow, 1'b0, 1'b1, rxPos);
                        rxEvtTgl_reg <= !rxEvtTgl_reg;
                    end
                end
                tsme_pkg::RX_LOAD: begin
                    if (rxPos == 3'h7) begin
                        rxEvt_reg <= rxMkEvt(1'b1, rxWindow, 1'b0, 1'b0, `TSME_OFFSET_NONE);
                        rxEvtTgl_reg <= !rxEvtTgl_reg;
                    end
                end
                default: rxState_reg <= tsme_pkg::RX_OFF;
            endcase
        end else begin
            rxSlotPrev_reg <= 1'b0;
        end
    end

endmodule : tsme_engine

`default_nettype wire

/* File: tsme_engine_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module tsme_engine_checker (
    // Host side
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] regAddr,
    input wire logic regRd,
    input wire logic regHit,
    input wire logic [7:0] regRdData,
    input wire logic bankSelectBit,
    input wire logic txEnableBit,
    input wire logic txResetBit,
    input wire logic txFifoValid,
    input wire logic txFifoPop,
    // Receive writes and events
    input wire logic [7:0] rxFifoWrData,
    input wire logic rxFifoWr,
    input wire logic txFinishedEvent,
    input wire logic txEmptyEvent,
    input wire logic underrunAbortEvent,
    input wire logic rxFrameEndEvent,
    input wire logic rxIdleEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Register bank decode and read hold
    hit_decode_a: assert property (regHit == (bankSelectBit && regAddr >= 4'hb && regAddr <= 4'hd))
        else $error("register hit decode wrong");
    read_hold_a: assert property (!(regRd && regHit) |=> $stable(regRdData))
        else $error("read data moved without a read");
    // Transmit FIFO pops
    pop_gate_a: assert property (txFifoPop |-> txFifoValid && txEnableBit)
        else $error("pop without data or enable");
    pop_spacing_a: assert property (txFifoPop |=> !txFifoPop [*3])
        else $error("pops too close together");
    // Events
    tx_reset_events_a: assert property (txResetBit |=> txFinishedEvent && txEmptyEvent)
        else $error("transmit reset events missing");
    no_underrun_a: assert property (!underrunAbortEvent)
        else $error("underrun abort raised");
    no_rx_idle_a: assert property (!rxIdleEvent)
        else $error("receiver idle raised");
    fill_status_a: assert property (rxFifoWr && rxFrameEndEvent |-> rxFifoWrData == 8'h90)
        else $error("short fill status byte wrong");
    frame_end_pulse_a: assert property (rxFrameEndEvent |=> !rxFrameEndEvent)
        else $error("frame end longer than one cycle");
    cover property (txFifoPop);
    cover property (rxFifoWr && rxFrameEndEvent);
    cover property (rxFifoWr && !rxFrameEndEvent);
endmodule : tsme_engine_checker
bind tsme_engine tsme_engine_checker checker_u (.clk, .srst, .regAddr, .regRd, .regHit, .regRdData,
    .bankSelectBit, .txEnableBit, .txResetBit, .txFifoValid, .txFifoPop, .rxFifoWrData, .rxFifoWr,
    .txFinishedEvent, .txEmptyEvent, .underrunAbortEvent, .rxFrameEndEvent, .rxIdleEvent);
`default_nettype wire

/* File: tsme_link_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tsme_link_model (
    // Line clocks
    output logic txBitClock,
    output logic rxBitClock,
    // Serial lines
    input wire logic txOutA,
    output logic rxInA,
    output logic rxInB,
    output logic [7:0] txWin
);
    // Line clocks run free; the transceiver times the line continuously
    initial begin
        txBitClock = 1'b0;
        #1.3;
        forever #3 txBitClock = ~txBitClock;
    end
    initial begin
        rxBitClock = 1'b0;
        rxInA = 1'b1;
        #2.1;
        forever #3 rxBitClock = ~rxBitClock;
    end
    // Input B shows the inverse of input A, so a wrong select is seen
    assign rxInB = ~rxInA;
    // earliest bit ends in bit 0
    always @(negedge txBitClock) txWin <= {txOutA, txWin[7:1]};
    task automatic sendByte(input logic [7:0] value);
        for (int i = 0; i < 8; i++) begin
            @(negedge rxBitClock);
            rxInA = value[i];
        end
    endtask : sendByte
    task automatic sendOnes(input int count);
        repeat (count) begin
            @(negedge rxBitClock);
            rxInA = 1'b1;
        end
    endtask : sendOnes
endmodule : tsme_link_model
`default_nettype wire

/* File: tsme_testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, srst, regWr, regRd, regHit, bankSelectBit, txEnableBit, rxEnableBit, txResetBit, rxResetBit;
    logic txOutAEnableBit, rxInputSelect, txFifoValid, txFifoPop, rxFifoWr, txFinishedEvent, txEmptyEvent;
    logic rxFrameEndEvent, txBitClock, rxBitClock, txOutA, txOutAOe, rxInA, rxInB, hit;
    logic txOutBEnableBit, txOutB, txOutBOe, underrunAbortEvent, rxIdleEvent;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData, txFifoData, rxFifoWrData, txWin, rd, txWinB;
    logic [7:0] wrLog [0:3];
    int nWr, nEnd, cycles, nMismatch, nCompared;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    tsme_engine dut_u (.clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regHit, .regRdData, .bankSelectBit,
        .txEnableBit, .rxEnableBit, .txResetBit, .rxResetBit, .tdmHighwayEnable(1'b0), .txOutAEnableBit,
        .txOutBEnableBit, .rxInputSelect, .txBitOrder(1'b0), .rxBitOrder(1'b0), .txFifoData,
        .txFifoValid, .txFifoPop, .rxFifoWrData, .rxFifoWr, .txFinishedEvent, .txEmptyEvent,
        .underrunAbortEvent, .rxFrameEndEvent, .rxIdleEvent, .txBitClock, .txSlotActive(1'b0), .txOutA,
        .txOutAOe, .txOutB, .txOutBOe, .rxBitClock, .rxSlotActive(1'b0), .rxInA, .rxInB);
    tsme_link_model link_u (.txBitClock, .rxBitClock, .txOutA, .rxInA, .rxInB, .txWin);
    // Second output collected like the first, earliest bit ends in bit 0
    always @(negedge txBitClock) txWinB <= {txOutB, txWinB[7:1]};
    // Log receive writes; cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rxFifoWr === 1'b1 && nWr < 4) wrLog[nWr] <= rxFifoWrData;
        if (rxFifoWr === 1'b1) nWr <= nWr + 1;
        if (rxFrameEndEvent === 1'b1) nEnd <= nEnd + 1;
        if (cycles == 20000) begin
            nMismatch++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [7:0] expected, input logic [7:0] seen);
        nCompared++;
        if (seen !== expected) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", what, expected, seen);
        end
    endtask : check
    task automatic regWrite(input logic [3:0] addr, input logic [7:0] data);
        @(negedge clk);
        regAddr = addr;
        regWrData = data;
        regWr = 1'b1;
        @(negedge clk);
        regWr = 1'b0;
    endtask : regWrite
    task automatic regRead(input logic [3:0] addr);
        @(negedge clk);
        regAddr = addr;
        regRd = 1'b1;
        #1 hit = regHit;
        @(negedge clk);
        regRd = 1'b0;
        rd = regRdData;
    endtask : regRead
    task automatic testRegisters();
        regRead(4'hb);
        check("mode reset", 8'h00, rd);
        regRead(4'hc);
        check("match reset", 8'h00, rd);
        regRead(4'hd);
        check("idle reset", 8'hff, rd);
        regWrite(4'hc, 8'h5a);
        regWrite(4'hd, 8'hc3);
        regRead(4'hc);
        check("match rw", 8'h5a, rd);
        regRead(4'ha);
        check("unmapped hit", 8'h00, {7'h0, hit});
        check("unmapped hold", 8'h5a, rd);
        bankSelectBit = 1'b0;
        regRead(4'hc);
        check("bank off hit", 8'h00, {7'h0, hit});
        bankSelectBit = 1'b1;
        $display("registers test done");
    endtask : testRegisters
    task automatic testTransmit();
        regWrite(4'hb, 8'h60);
        txResetBit = 1'b1;
        @(negedge clk);
        txResetBit = 1'b0;
        txFifoData = 8'h3c;
        txFifoValid = 1'b1;
        {txOutAEnableBit, txOutBEnableBit} = 2'b11;
        txEnableBit = 1'b1;
        for (int i = 0; i < 300 && txFifoPop !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        txFifoValid = 1'b0;
        @(negedge clk);
        check("tx finished", 8'h01, {7'h0, txFinishedEvent});
        // Match is on, so the idle character written earlier goes out first
        for (int i = 0; i < 300 && txWin !== 8'hc3; i++) @(negedge clk);
        check("idle first", 8'hc3, txWin);
        for (int i = 0; i < 300 && txWin !== 8'h3c; i++) @(negedge clk);
        check("tx byte", 8'h3c, txWin);
        check("tx byte b", 8'h3c, txWinB);
        check("tx oe", 8'h03, {6'h0, txOutAOe, txOutBOe});
        txEnableBit = 1'b0;
        txResetBit = 1'b1;
        @(negedge clk);
        txResetBit = 1'b0;
        check("tx reset events", 8'h03, {6'h0, txFinishedEvent, txEmptyEvent});
        check("no underrun", 8'h00, {7'h0, underrunAbortEvent});
        $display("transmit test done");
    endtask : testTransmit
    task automatic testReceive();
        regWrite(4'hc, 8'ha5);
        regWrite(4'hb, 8'h60);
        nWr = 0;
        rxInputSelect = 1'b1;
        rxEnableBit = 1'b1;
        repeat (30) @(negedge clk);
        // Input B shows line A inverted, so the line carries inverted bytes
        link_u.sendOnes(5);
        link_u.sendByte(8'h5a);
        link_u.sendByte(8'hbd);
        // Stop before a further idle byte could be loaded
        @(negedge clk);
        rxEnableBit = 1'b0;
        repeat (20) @(negedge clk);
        check("no rx idle", 8'h00, {7'h0, rxIdleEvent});
        check("rx count", 8'h02, nWr[7:0]);
        check("rx match byte", 8'ha5, wrLog[0]);
        check("rx next byte", 8'h42, wrLog[1]);
        regRead(4'hb);
        check("found flag", 8'h01, {7'h0, rd[4]});
        rxResetBit = 1'b1;
        @(negedge clk);
        rxResetBit = 1'b0;
        rxInputSelect = 1'b0;
        $display("receive test done");
    endtask : testReceive
    task automatic testFill();
        regWrite(4'hb, 8'h00);
        rxEnableBit = 1'b1;
        repeat (30) @(negedge clk);
        nWr = 0;
        nEnd = 0;
        link_u.sendByte(8'h7e);
        link_u.sendOnes(1);
        link_u.sendByte(8'h7e);
        link_u.sendOnes(3);
        link_u.sendByte(8'h7e);
        link_u.sendOnes(6);
        link_u.sendByte(8'h7e);
        repeat (30) @(negedge clk);
        check("fill ends", 8'h02, nEnd[7:0]);
        check("fill writes", 8'h01, nWr[7:0]);
        check("fill status", 8'h90, wrLog[0]);
        $display("fill test done");
    endtask : testFill
    task automatic conclude();
        $display("compared %0d mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    // Quiet inputs, then reset for 12 cycles
    initial begin
        {regWr, regRd, txEnableBit, rxEnableBit, txResetBit, rxResetBit, txOutAEnableBit, txOutBEnableBit} = 8'h00;
        {rxInputSelect, txFifoValid, nWr, nEnd, cycles, nMismatch, nCompared} = '0;
        {regAddr, regWrData, txFifoData} = '0;
        bankSelectBit = 1'b1;
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        testRegisters();
        testTransmit();
        testReceive();
        testFill();
        conclude();
    end
endmodule : testbench
`default_nettype wire
